/* File: include/adc_port_pkg.sv */
// Purpose: Shared constants for the parallel converter host port
// Assumes: 100 MHz sys_clk
// Notes: Control register bits follow the data-line map below
package adc_port_pkg;
	// =====================================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int EOC_TIME_NS = 80;
	localparam int EOC_CYCLES = (EOC_TIME_NS / CLK_PERIOD_NS) < 1 ? 1
		: (EOC_TIME_NS / CLK_PERIOD_NS);
	localparam int CNT_W = 16;
	localparam int SETTLE_CYCLES_DEF = 200;
	localparam int CONV_CYCLES_DEF = 160;
	localparam int SYNC_STAGES = 2;

	// =====================================================
	// Data lines
	localparam int DATA_W = 12;
	localparam int DATA_MSB = 11;
	localparam int DL_CH_BIT2 = 6;
	localparam int DL_CH_BIT1 = 7;
	localparam int DL_CH_BIT0 = 8;
	localparam int DL_SOFT_CONV = 9;
	localparam int DL_SOFT_STBY = 10;
	localparam int DL_FORMAT = 11;

	// =====================================================
	// channel_and_conversion_control layout
	localparam int CTRL_W = 6;
	localparam int CTRL_FORMAT = 0;
	localparam int CTRL_SOFT_STBY = 1;
	localparam int CTRL_SOFT_CONV = 2;
	localparam int CTRL_CH_BIT0 = 3;
	localparam int CTRL_CH_BIT1 = 4;
	localparam int CTRL_CH_BIT2 = 5;
	localparam logic [5:0] CTRL_RESET = 6'h00;
	localparam logic [3:0] CHANNEL_BASE = 4'h1;

	typedef enum logic [1:0] {
		CONV_IDLE = 2'b00,
		CONV_BUSY = 2'b01,
		CONV_DONE = 2'b10
	} conv_state_type;
endpackage

/* File: src/pin_sync.sv */
// Purpose: Two-stage synchroniser for asynchronous pins
// Assumes: Every bit is an independent level
// Notes: Only the second stage is visible outside
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinSync
);
	logic [WIDTH-1:0] stage1_r;
	logic [WIDTH-1:0] stage2_r;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stage1_r <= INIT;
			stage2_r <= INIT;
		end else begin
			stage1_r <= pinIn;
			stage2_r <= stage1_r;
		end
	end

	assign pinSync = stage2_r;
endmodule // pin_sync

/* File: src/adc_parallel_host_port.sv */
// Purpose: Parallel host port of an eight-channel converter
// Assumes: Pins are asynchronous; converter core result is on sys_clk
// Notes: Bus strobes act only while interfaceSel is high; the trigger starts conversions in both modes
//
// Overview of operation
// - Drive data only with select and read low
// - Select plus write captures control bits
// - Write rising edge starts settling pulse
// - Conversion bit set: convert when settling ends
// - Conversion bit clear: writes leave converter alone
// - Parallel mode: lines carry result and control
// - Result bit 0 LSB, 11 MSB, three-state
// - Format bit picks twos complement or binary
// - Write latches six control bits
// - End of conversion: low pulse, 80 ns
// - Trigger rising edge starts a conversion
// - Control bits clear at power-on
// - Channel number is select value plus one
`timescale 1ns/100ps
module adc_parallel_host_port #(
	parameter int SETTLE_CYCLES = adc_port_pkg::SETTLE_CYCLES_DEF,
	parameter int CONV_CYCLES = adc_port_pkg::CONV_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic interfaceSel,
	input wire logic chipSelN,
	input wire logic readN,
	input wire logic writeN,
	input wire logic convertTrigger,
	input wire logic [11:0] sharedDataIn,
	output logic [11:0] sharedDataOut,
	output logic sharedDataOe,
	input wire logic [11:0] sampleCode,
	output logic trackHold,
	output logic endConvN,
	output logic softStandby,
	output logic [3:0] channelNum
);
	// =====================================================
	// Pin synchronisation
	logic [4:0] ctlSync;
	logic [11:0] dataSync;
	logic modeQ;
	logic csQ;
	logic rdQ;
	logic wrQ;
	logic trigQ;

	pin_sync #(.WIDTH(5), .INIT(5'h0e)) ctlSyncInst (
		.sys_clk(sys_clk),
		.srst(srst),
		.pinIn({interfaceSel, chipSelN, readN, writeN, convertTrigger}),
		.pinSync(ctlSync)
	);

	pin_sync #(.WIDTH(12), .INIT(12'h000)) dataSyncInst (
		.sys_clk(sys_clk),
		.srst(srst),
		.pinIn(sharedDataIn),
		.pinSync(dataSync)
	);

	assign modeQ = ctlSync[4];
	assign csQ = ctlSync[3];
	assign rdQ = ctlSync[2];
	assign wrQ = ctlSync[1];
	assign trigQ = ctlSync[0];

	// =====================================================
	// Edge detection
	logic wrPrev_r;
	logic trigPrev_r;
	logic wrRise;
	logic trigRise;
	logic wrActive;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wrPrev_r <= 1'b1;
			trigPrev_r <= 1'b0;
		end else begin
			wrPrev_r <= wrQ;
			trigPrev_r <= trigQ;
		end
	end

	assign wrRise = modeQ && wrQ && !wrPrev_r;
	assign trigRise = trigQ && !trigPrev_r;
	assign wrActive = modeQ && !csQ && !wrQ;

	// =====================================================
	// Control register
	logic [5:0] ctrl_r;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ctrl_r <= adc_port_pkg::CTRL_RESET;
		end else if (wrActive) begin
			ctrl_r[adc_port_pkg::CTRL_CH_BIT2] <= dataSync[adc_port_pkg::DL_CH_BIT2];
			ctrl_r[adc_port_pkg::CTRL_CH_BIT1] <= dataSync[adc_port_pkg::DL_CH_BIT1];
			ctrl_r[adc_port_pkg::CTRL_CH_BIT0] <= dataSync[adc_port_pkg::DL_CH_BIT0];
			ctrl_r[adc_port_pkg::CTRL_SOFT_CONV] <= dataSync[adc_port_pkg::DL_SOFT_CONV];
			ctrl_r[adc_port_pkg::CTRL_SOFT_STBY] <= dataSync[adc_port_pkg::DL_SOFT_STBY];
			ctrl_r[adc_port_pkg::CTRL_FORMAT] <= dataSync[adc_port_pkg::DL_FORMAT];
		end
	end

	assign softStandby = ctrl_r[adc_port_pkg::CTRL_SOFT_STBY];
	assign channelNum = {1'b0, ctrl_r[adc_port_pkg::CTRL_CH_BIT2],
		ctrl_r[adc_port_pkg::CTRL_CH_BIT1], ctrl_r[adc_port_pkg::CTRL_CH_BIT0]}
		+ adc_port_pkg::CHANNEL_BASE;

	// =====================================================
	// Settling pulse
	logic [15:0] settleCnt_r;
	logic settleExpire;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			settleCnt_r <= '0;
		end else if (wrRise) begin
			settleCnt_r <= 16'(SETTLE_CYCLES);
		end else if (settleCnt_r != '0) begin
			settleCnt_r <= settleCnt_r - 16'h0001;
		end
	end

	assign settleExpire = (settleCnt_r == 16'h0001) && !wrRise;

	// =====================================================
	// Conversion sequence
	adc_port_pkg::conv_state_type state_r;
	logic [15:0] convCnt_r;
	logic startConv;

	// Conversion bit gates the settle end
	assign startConv = trigRise
		|| (settleExpire && ctrl_r[adc_port_pkg::CTRL_SOFT_CONV]);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_r <= adc_port_pkg::CONV_IDLE;
			convCnt_r <= '0;
		end else begin
			case (state_r)
				adc_port_pkg::CONV_IDLE: begin
					if (startConv) begin
						state_r <= adc_port_pkg::CONV_BUSY;
						convCnt_r <= 16'(CONV_CYCLES - 1);
					end
				end
				adc_port_pkg::CONV_BUSY: begin
					if (convCnt_r == '0) begin
						state_r <= adc_port_pkg::CONV_DONE;
						convCnt_r <= 16'(adc_port_pkg::EOC_CYCLES - 1);
					end else begin
						convCnt_r <= convCnt_r - 16'h0001;
					end
				end
				adc_port_pkg::CONV_DONE: begin
					if (convCnt_r == '0) begin
						state_r <= adc_port_pkg::CONV_IDLE;
					end else begin
						convCnt_r <= convCnt_r - 16'h0001;
					end
				end
				default: begin
					state_r <= adc_port_pkg::CONV_IDLE;
				end
			endcase
		end
	end

	assign trackHold = (state_r == adc_port_pkg::CONV_BUSY);
	assign endConvN = (state_r != adc_port_pkg::CONV_DONE);

	// =====================================================
	// Result and read path
	logic [11:0] result_r;
	logic [11:0] readData_r;

	function automatic logic [11:0] code_format(input logic [11:0] code, input logic twos);
		code_format = twos ? {~code[adc_port_pkg::DATA_MSB], code[10:0]} : code;
	endfunction

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			result_r <= '0;
		end else if (state_r == adc_port_pkg::CONV_BUSY && convCnt_r == '0) begin
			result_r <= sampleCode;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			readData_r <= '0;
		end else begin
			readData_r <= code_format(result_r, ctrl_r[adc_port_pkg::CTRL_FORMAT]);
		end
	end

	assign sharedDataOut = readData_r;
	assign sharedDataOe = modeQ && !csQ && !rdQ;

	// =====================================================
	// Checks
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence settle_done_s;
		settleExpire && state_r == adc_port_pkg::CONV_IDLE && !trigRise;
	endsequence

	sequence eoc_pulse_s;
		!endConvN [*8] ##1 endConvN;
	endsequence

	out_enable_a: assert property (sharedDataOe |-> !csQ && !rdQ && modeQ)
		else $error("data driven without select and read");
	ctrl_capture_a: assert property (wrActive |=>
		ctrl_r[adc_port_pkg::CTRL_CH_BIT2] == $past(dataSync[adc_port_pkg::DL_CH_BIT2])
		&& ctrl_r[adc_port_pkg::CTRL_FORMAT] == $past(dataSync[adc_port_pkg::DL_FORMAT])
		&& ctrl_r[adc_port_pkg::CTRL_SOFT_CONV] == $past(dataSync[adc_port_pkg::DL_SOFT_CONV]))
		else $error("control bits not captured");
	settle_start_a: assert property (wrRise |=> settleCnt_r == 16'(SETTLE_CYCLES))
		else $error("settling pulse not started");
	hold_start_a: assert property ((settle_done_s
		and ctrl_r[adc_port_pkg::CTRL_SOFT_CONV]) |=> trackHold)
		else $error("conversion not started after settling");
	no_effect_a: assert property ((settle_done_s
		and !ctrl_r[adc_port_pkg::CTRL_SOFT_CONV]) |=> !trackHold)
		else $error("conversion started with conversion bit clear");
	read_format_a: assert property (1'b1 |=> readData_r ==
		code_format($past(result_r), $past(ctrl_r[adc_port_pkg::CTRL_FORMAT])))
		else $error("read coding wrong");
	eoc_width_a: assert property ($fell(endConvN) |-> eoc_pulse_s)
		else $error("end of conversion pulse width wrong");
	trig_conv_a: assert property (trigRise && state_r == adc_port_pkg::CONV_IDLE
		|=> trackHold)
		else $error("trigger edge did not start conversion");
	reset_ctrl_a: assert property ($fell(srst) |-> ctrl_r == adc_port_pkg::CTRL_RESET)
		else $error("control bits not cleared by reset");
	channel_num_a: assert property (channelNum == ({1'b0, ctrl_r[5:3]} + 4'h1))
		else $error("channel number wrong");
endmodule // adc_parallel_host_port

/* File: tb/host_model.sv */
// Purpose: Host processor on the parallel strobe port
// Assumes: Pins move 1 ns after sys_clk rises
// Notes: Released lines show the inverse of their last level
`timescale 1ns/100ps
module host_model (
	input wire logic sys_clk,
	input wire logic [11:0] sharedDataOut,
	input wire logic sharedDataOe,
	output logic chipSelN,
	output logic readN,
	output logic writeN,
	output logic convertTrigger,
	output logic [11:0] sharedDataIn
);
	logic [11:0] hostData = 12'h000;
	logic hostDrive = 1'b0;
	logic [11:0] lastLvl = 12'h000;
	// Idle strobe levels at start
	initial begin
		chipSelN = 1'b1;
		readN = 1'b1;
		writeN = 1'b1;
		convertTrigger = 1'b0;
	end
	// ==========================================
	// Wire level
	always_comb sharedDataIn = sharedDataOe ? sharedDataOut : (hostDrive ? hostData : ~lastLvl);
	always @(posedge sys_clk) begin
		if (sharedDataOe || hostDrive) lastLvl <= sharedDataIn;
	end
	// ==========================================
	// Strobe cycles
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic writeCtrl(input logic [11:0] d);
		tick(1);
		hostData = d;
		hostDrive = 1'b1;
		chipSelN = 1'b0;
		writeN = 1'b0;
		tick(4);
		writeN = 1'b1;
		tick(2);
		chipSelN = 1'b1;
		hostDrive = 1'b0;
	endtask
	task automatic readData(output logic [11:0] q, output logic seen);
		int n;
		tick(1);
		chipSelN = 1'b0;
		readN = 1'b0;
		for (n = 0; n < 6 && sharedDataOe !== 1'b1; n++) tick(1);
		seen = (sharedDataOe === 1'b1);
		q = sharedDataIn;
		readN = 1'b1;
		chipSelN = 1'b1;
	endtask
	task automatic pulseTrigger();
		tick(1);
		convertTrigger = 1'b1;
		tick(3);
		convertTrigger = 1'b0;
	endtask
endmodule // host_model

/* File: tb/adc_parallel_host_port_bench.sv */
// Purpose: Self-checking bench for the parallel host port
// Assumes: Short settle and conversion counts
// Notes: The control-write scenario works out its expected control bits inline, the conversion scenarios their expected result
`timescale 1ns/100ps
module adc_parallel_host_port_bench;
	localparam int SETTLE = 4;
	localparam int CONV = 4;
	localparam int EOC_LEN = 80 / 10;
	logic sys_clk = 1'b0;
	logic srst;
	logic interfaceSel;
	logic [11:0] sampleCode;
	logic chipSelN, readN, writeN, convertTrigger, trackHold, endConvN, softStandby, sharedDataOe;
	logic [11:0] sharedDataIn, sharedDataOut;
	logic [3:0] channelNum;
	logic [31:0] lfsr_r = 32'h0000d44e;
	logic seen;
	int nMismatch = 0;
	int nTests = 0;
	int cycles = 0;
	int thCnt = 0;
	always #5 sys_clk = ~sys_clk;
	adc_parallel_host_port #(.SETTLE_CYCLES(SETTLE), .CONV_CYCLES(CONV)) DUT (
		.sys_clk(sys_clk), .srst(srst), .interfaceSel(interfaceSel), .chipSelN(chipSelN),
		.readN(readN), .writeN(writeN), .convertTrigger(convertTrigger),
		.sharedDataIn(sharedDataIn), .sharedDataOut(sharedDataOut), .sharedDataOe(sharedDataOe),
		.sampleCode(sampleCode), .trackHold(trackHold), .endConvN(endConvN),
		.softStandby(softStandby), .channelNum(channelNum));
	host_model host (.sys_clk(sys_clk), .sharedDataOut(sharedDataOut),
		.sharedDataOe(sharedDataOe), .chipSelN(chipSelN), .readN(readN), .writeN(writeN),
		.convertTrigger(convertTrigger), .sharedDataIn(sharedDataIn));
	// ==========================================
	// Helpers
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic rnd(output logic [11:0] v);
		lfsr_r = nextRand(lfsr_r);
		v = lfsr_r[11:0];
	endtask
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		nTests++;
		if (got !== exp) begin
			nMismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("Counts: %0d compares, %0d mismatches", nTests, nMismatch);
		if (nMismatch == 0 && nTests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic convCheck();
		int n;
		int k;
		for (n = 0; n < 40 && trackHold !== 1'b1; n++) host.tick(1);
		for (k = 0; k < 40 && trackHold === 1'b1; k++) host.tick(1);
		chk(12'(k), 12'(CONV));
		for (n = 0; n < 4 && endConvN !== 1'b0; n++) host.tick(1);
		for (k = 0; k < 40 && endConvN === 1'b0; k++) host.tick(1);
		chk(12'(k), 12'(EOC_LEN));
	endtask
	always @(posedge sys_clk) begin
		if (trackHold === 1'b1) thCnt++;
		cycles++;
		if (cycles == 6000) begin
			nMismatch++;
			wrap_up();
		end
	end
	// ==========================================
	// Scenarios
	initial begin
		logic [11:0] r;
		logic [11:0] d;
		srst = 1'b1;
		interfaceSel = 1'b1;
		sampleCode = 12'h000;
		host.tick(20);
		srst = 1'b0;
		host.tick(3);
		chk({sharedDataOe, trackHold, endConvN, softStandby, channelNum, 4'h0}, 12'h210);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			rnd(d);
			d[9] = 1'b0;
			d[8:6] = {i[0], i[1], i[2]};
			host.writeCtrl(d);
			host.tick(3);
			chk({7'h0, softStandby, channelNum}, {7'h0, d[10], 4'(i + 1)});
		end
		host.tick(SETTLE + 4);
		chk(12'(thCnt), 12'h000);
		$display("test control writes done");
		for (int f = 0; f < 2; f++) begin
			rnd(d);
			sampleCode = d;
			host.writeCtrl({f[0], 1'b0, 1'b1, 3'h5, 6'h00});
			convCheck();
			host.readData(r, seen);
			chk({11'h0, seen}, 12'h001);
			chk(r, f[0] ? (d ^ 12'h800) : d);
		end
		$display("test soft convert done");
		host.writeCtrl(12'h000);
		host.tick(SETTLE + 4);
		rnd(d);
		sampleCode = d;
		host.pulseTrigger();
		convCheck();
		host.readData(r, seen);
		chk(r, d);
		$display("test trigger done");
		interfaceSel = 1'b0;
		host.tick(3);
		host.writeCtrl(12'hfc0);
		host.tick(3);
		chk({8'h0, channelNum}, 12'h001);
		host.readData(r, seen);
		chk({11'h0, seen}, 12'h000);
		$display("test serial mode done");
		wrap_up();
	end
endmodule // adc_parallel_host_port_bench
